// >>> rtl/fault_protection_manager.sv
// Fault protection manager: fault detections to resets, shutdowns,
// latched status bits and wake/fault signalling towards the host.
// Assumes detector inputs are asynchronous levels; the serial link
// runs on its own clock link_clk; host control arrives on core_clk.
// Behaviour
// R1: Watchdog failure asserts reset and latches watchdog flag until read.
// R2: In stop mode watchdog off only below current threshold, not commanded.
// R3: Regulator overtemp shuts output off, reset below threshold, auto-restart.
// R4: Internal undervoltage resets, clears configuration, shows in status.
// R5: Low-side fault switches drivers off, latches status, signals fault.
// R6: Low-side fault also pulses the fault line to notify the host.
// R7: Lamp driver fault turns it off, latched status, command re-enables.
// R8: Battery under/overvoltage latches status, optionally shuts lamp driver.
// R9: Main-supply undervoltage latched until next status read.
// R10: LIN failure reported unlatched: overtemp, undervoltage or timeout.
// R11: LIN wake drives receive line and serial output low, reports source.
// R12: Sense wake drives serial output low and reports source.
// R13: With select active, serial output shows failure ORed with serial in.
// R14: Watchdog reset flag cleared by any serial access.
// R15: Fault line low exactly one oscillator cycle on low-side shutdown.
// R16: Event coinciding with clearing read keeps the flag set.
// R17: Host re-enables outputs only after reading the fault status; the code accepts the enable write once the detector clears, read or not.
`timescale 1ns/1ps
`include "fault_protection_manager_defines.svh"
module fault_protection_manager
    import fault_protection_manager_pkg::*;
(
    // Oscillator clock and internal-supply reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Serial link clock domain
    input  wire logic                  link_clk,
    input  wire logic                  link_rst,
    input  wire logic                  chip_select_n,
    input  wire logic                  serial_in_line,
    input  wire logic                  status_read,
    // Detector levels and wake events
    input  wire fault_in_t             fault_in,
    input  wire logic                  lin_wake,
    input  wire logic [`SENSE_N-1:0]   sense_wake_input,
    input  wire logic                  reg_current_high,
    // Host control, same clock domain
    input  wire ctrl_t                 ctrl_in,
    input  wire logic                  ctrl_write,
    input  wire op_mode_t              mode_in,
    // Outputs towards host and drivers
    output logic                       reset_out_n_reg,
    output logic                       fault_line_n_reg,
    output logic                       rx_line_n_reg,
    output logic                       serial_out_reg,
    output logic                       low_side_switch_en_reg,
    output logic                       high_side_lamp_driver_en_reg,
    output logic                       supply_en_reg,
    output logic                       regulator_output_en_reg,
    output logic                       window_watchdog_en_reg,
    output logic [`STAT_W-1:0]         status_reg
);

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    fault_in_t              fault_s;
    logic [`SENSE_N+2:0]    misc_s;
    logic                   lin_wake_s;
    logic [`SENSE_N-1:0]    sense_s;
    logic                   cur_high_s;
    logic                   read_tog_s;
    // Crossing sources, declared ahead of the synchronisers that read them
    logic                   read_tog_link_reg;
    logic                   any_fail_reg;
    logic                   wake_pend_reg;

    sync_bit #(.WIDTH($bits(fault_in_t))) u_sync_fault (
        .clk      (core_clk),
        .rst      (rst),
        .async_in (fault_in),
        .sync_out (fault_s)
    );

    sync_bit #(.WIDTH(`SENSE_N + 3)) u_sync_misc (
        .clk      (core_clk),
        .rst      (rst),
        .async_in ({read_tog_link_reg, reg_current_high,
                    sense_wake_input, lin_wake}),
        .sync_out (misc_s)
    );

    assign lin_wake_s = misc_s[0];
    assign sense_s    = misc_s[`SENSE_N:1];
    assign cur_high_s = misc_s[`SENSE_N+1];
    assign read_tog_s = misc_s[`SENSE_N+2];

    // ****************************************************************
    // Serial link domain: read event as toggle, failure level in
    // ****************************************************************
    logic fail_link_meta_reg;
    logic fail_link_reg;
    logic wake_link_meta_reg;
    logic wake_link_reg;

    // Each completed status read flips the toggle for the core side
    always_ff @(posedge link_clk) begin
        if (link_rst)
            read_tog_link_reg <= 1'b0;
        else if (status_read)
            read_tog_link_reg <= ~read_tog_link_reg;
    end

    // Failure and wake levels cross into the link domain
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            fail_link_meta_reg <= 1'b0;
            fail_link_reg      <= 1'b0;
            wake_link_meta_reg <= 1'b0;
            wake_link_reg      <= 1'b0;
        end else begin
            fail_link_meta_reg <= any_fail_reg;
            fail_link_reg      <= fail_link_meta_reg;
            wake_link_meta_reg <= wake_pend_reg;
            wake_link_reg      <= wake_link_meta_reg;
        end
    end

    // Output line: failure ORed with input while selected, low on wake
    always_ff @(posedge link_clk) begin
        if (link_rst)
            serial_out_reg <= 1'b1;
        else if (!chip_select_n)
            serial_out_reg <= fail_link_reg | serial_in_line; // R13
        else
            serial_out_reg <= ~wake_link_reg;                 // R11 R12
    end

    // ****************************************************************
    // Read event and edge detection in the core domain
    // ****************************************************************
    logic read_tog_d_reg;
    logic read_pulse;
    logic lsw_d_reg;
    logic lsw_rise;
    logic wdog_d_reg;
    logic wdog_rise;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            read_tog_d_reg <= 1'b0;
            lsw_d_reg      <= 1'b0;
            wdog_d_reg     <= 1'b0;
        end else begin
            read_tog_d_reg <= read_tog_s;
            lsw_d_reg      <= fault_s.lsw_fault;
            wdog_d_reg     <= fault_s.wdog_fail;
        end
    end

    assign read_pulse = read_tog_s ^ read_tog_d_reg;
    assign lsw_rise   = fault_s.lsw_fault & ~lsw_d_reg;
    assign wdog_rise  = fault_s.wdog_fail & ~wdog_d_reg;

    // ****************************************************************
    // Latched status flags
    // ****************************************************************
    logic wdog_flag;
    logic lsw_flag;
    logic lamp_flag;
    logic supply_flag;
    logic bat_uv_flag;
    logic bat_ov_flag;
    logic main_uv_flag;
    logic prewarn_flag;

    latch_flag u_wdog (.clk(core_clk), .rst(rst), .set_in(wdog_rise),
        .clr_in(read_pulse), .flag_reg(wdog_flag));                // R1 R14
    latch_flag u_lsw (.clk(core_clk), .rst(rst), .set_in(lsw_rise),
        .clr_in(read_pulse), .flag_reg(lsw_flag));                 // R5
    latch_flag u_lamp (.clk(core_clk), .rst(rst),
        .set_in(fault_s.lamp_fault), .clr_in(read_pulse),
        .flag_reg(lamp_flag));                                     // R7
    latch_flag u_supply (.clk(core_clk), .rst(rst),
        .set_in(fault_s.supply_fault), .clr_in(read_pulse),
        .flag_reg(supply_flag));
    latch_flag u_bat_uv (.clk(core_clk), .rst(rst),
        .set_in(fault_s.bat_uv), .clr_in(read_pulse),
        .flag_reg(bat_uv_flag));                                   // R8
    latch_flag u_bat_ov (.clk(core_clk), .rst(rst),
        .set_in(fault_s.bat_ov), .clr_in(read_pulse),
        .flag_reg(bat_ov_flag));                                   // R8
    latch_flag u_main_uv (.clk(core_clk), .rst(rst),
        .set_in(fault_s.main_uv), .clr_in(read_pulse),
        .flag_reg(main_uv_flag));                                  // R9
    latch_flag u_prewarn (.clk(core_clk), .rst(rst),
        .set_in(fault_s.reg_prewarn), .clr_in(read_pulse),
        .flag_reg(prewarn_flag));

    // ****************************************************************
    // Wake latches: held until the host reads the source
    // ****************************************************************
    logic                 lin_wake_reg;
    logic [`SENSE_N-1:0]  sense_wake_reg;
    logic                 low_power;

    assign low_power = (mode_in == MODE_STOP) || (mode_in == MODE_SLEEP);

    // Set wins over the clearing read, as for the fault flags
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lin_wake_reg   <= 1'b0;
            sense_wake_reg <= '0;
        end else begin
            lin_wake_reg   <= (low_power & lin_wake_s) |
                              (lin_wake_reg & ~read_pulse);       // R11 R16
            sense_wake_reg <= ({`SENSE_N{low_power}} & sense_s) |
                              (sense_wake_reg &
                               {`SENSE_N{~read_pulse}});          // R12 R16
        end
    end

    // Wake lines stay low until read, a level the host can sample
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wake_pend_reg <= 1'b0;
            rx_line_n_reg <= 1'b1;
        end else begin
            wake_pend_reg <= lin_wake_reg | (|sense_wake_reg);
            rx_line_n_reg <= ~lin_wake_reg;                       // R11
        end
    end

    // ****************************************************************
    // Output enables: shutdown on fault, re-enable by command except the regulator
    // ****************************************************************
    logic bat_trip;
    assign bat_trip = ctrl_in.bat_lamp_shutdown &
                      (fault_s.bat_uv | fault_s.bat_ov);

    // Configuration cleared by reset; host rewrites enables after reading
    always_ff @(posedge core_clk) begin
        if (rst || wdog_rise) begin
            low_side_switch_en_reg       <= 1'b0;                 // R4
            high_side_lamp_driver_en_reg <= 1'b0;
            supply_en_reg                <= 1'b0;
        end else begin
            if (fault_s.lsw_fault)
                low_side_switch_en_reg <= 1'b0;                   // R5
            else if (ctrl_write)
                low_side_switch_en_reg <= ctrl_in.lsw_enable;     // R17
            if (fault_s.lamp_fault || bat_trip)
                high_side_lamp_driver_en_reg <= 1'b0;             // R7 R8
            else if (ctrl_write)
                high_side_lamp_driver_en_reg <= ctrl_in.lamp_enable;
            if (fault_s.supply_fault)
                supply_en_reg <= 1'b0;
            else if (ctrl_write)
                supply_en_reg <= ctrl_in.supply_enable;
        end
    end

    // Regulator restarts by itself once overtemp clears with hysteresis
    always_ff @(posedge core_clk) begin
        if (rst)
            regulator_output_en_reg <= 1'b1;
        else
            regulator_output_en_reg <= ~fault_s.reg_overtemp;     // R3
    end

    // ****************************************************************
    // Reset and fault strobes
    // ****************************************************************
    // Reset on watchdog failure or regulator below reset threshold
    always_ff @(posedge core_clk) begin
        if (rst)
            reset_out_n_reg <= 1'b0;                              // R4
        else
            reset_out_n_reg <= ~(fault_s.wdog_fail |
                                 fault_s.reg_below_reset);        // R1 R3
    end

    // One cycle low strobe; the host sees the event without polling
    always_ff @(posedge core_clk) begin
        if (rst)
            fault_line_n_reg <= 1'b1;
        else
            fault_line_n_reg <= ~lsw_rise;                        // R6 R15
    end

    // Watchdog stays on in stop mode unless current low and not commanded
    always_ff @(posedge core_clk) begin
        if (rst)
            window_watchdog_en_reg <= 1'b1;
        else if (mode_in == MODE_STOP)
            window_watchdog_en_reg <= cur_high_s |
                                      ctrl_in.wdog_stop_enable;   // R2
        else
            window_watchdog_en_reg <= 1'b1;
    end

    // ****************************************************************
    // Status word
    // ****************************************************************
    // Failure summary for the serial indicator
    always_ff @(posedge core_clk) begin
        if (rst)
            any_fail_reg <= 1'b0;
        else
            any_fail_reg <= wdog_flag | lsw_flag | lamp_flag |
                            supply_flag | fault_s.lin_fail;
    end

    // Wake sources replace sense levels while a wake is pending
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_reg <= '0;                                     // R4
        end else begin
            status_reg[`STAT_REG_PREWARN] <= prewarn_flag;
            status_reg[`STAT_LAMP_FAIL]   <= lamp_flag;
            status_reg[`STAT_VINT_OK]     <= 1'b1;                // R4
            status_reg[`STAT_LSW_FAIL]    <= lsw_flag;
            status_reg[`STAT_WDOG_RESET]  <= wdog_flag;
            status_reg[`STAT_SENSE_LO +: `SENSE_N] <=
                wake_pend_reg ? sense_wake_reg : sense_s;
            status_reg[10]                <= 1'b0;
            status_reg[`STAT_LIN_INFO]    <= wake_pend_reg ?
                lin_wake_reg : fault_s.lin_fail;                  // R10
            status_reg[`STAT_BAT_UV]      <= bat_uv_flag;
            status_reg[`STAT_BAT_OV]      <= bat_ov_flag;
            status_reg[`STAT_SUPPLY_FAIL] <= supply_flag;
            status_reg[`STAT_MAIN_UV]     <= main_uv_flag;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_fault_strobe;
        @(posedge core_clk) disable iff (rst)
        lsw_rise |=> !fault_line_n_reg ##1 fault_line_n_reg;
    endproperty
    a_fault_strobe: assert property (p_fault_strobe) // R15
        else $error("fault line strobe not one cycle");

    property p_lsw_off;
        @(posedge core_clk) disable iff (rst)
        fault_s.lsw_fault |=> !low_side_switch_en_reg;
    endproperty
    a_lsw_off: assert property (p_lsw_off) // R5
        else $error("low side switch not shut down");

    property p_wdog_reset;
        @(posedge core_clk) disable iff (rst)
        wdog_rise |=> !reset_out_n_reg && wdog_flag;
    endproperty
    a_wdog_reset: assert property (p_wdog_reset) // R1
        else $error("watchdog failure without reset and flag");

    property p_set_wins;
        @(posedge core_clk) disable iff (rst)
        (lsw_rise && read_pulse) |=> lsw_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) // R16
        else $error("coincident event lost");

    property p_reg_ot;
        @(posedge core_clk) disable iff (rst)
        fault_s.reg_overtemp |=> !regulator_output_en_reg;
    endproperty
    a_reg_ot: assert property (p_reg_ot) // R3
        else $error("regulator not shut down on overtemp");

    property p_wdog_stop;
        @(posedge core_clk) disable iff (rst)
        (mode_in == MODE_STOP && cur_high_s) |=> window_watchdog_en_reg;
    endproperty
    a_wdog_stop: assert property (p_wdog_stop) // R2
        else $error("watchdog off above current threshold");

    property p_lamp_off;
        @(posedge core_clk) disable iff (rst)
        (fault_s.lamp_fault || bat_trip) |=> !high_side_lamp_driver_en_reg;
    endproperty
    a_lamp_off: assert property (p_lamp_off) // R7
        else $error("lamp driver not shut down");

    property p_flag_clear;
        @(posedge core_clk) disable iff (rst)
        (read_pulse && !wdog_rise) |=> !wdog_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R14
        else $error("watchdog flag not cleared by access");

endmodule

// >>> rtl/fault_protection_manager_defines.svh
// Constants of the fault protection manager: status word layout, widths.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FAULT_PROTECTION_MANAGER_DEFINES_SVH
`define FAULT_PROTECTION_MANAGER_DEFINES_SVH

// ****************************************************************
// Status word bit positions
// ****************************************************************
`define STAT_W            16
`define STAT_REG_PREWARN  0
`define STAT_LAMP_FAIL    1
`define STAT_VINT_OK      2
`define STAT_LSW_FAIL     3
`define STAT_WDOG_RESET   4
`define STAT_SENSE_LO     5
`define SENSE_N           5
`define STAT_LIN_INFO     11
`define STAT_BAT_UV       12
`define STAT_BAT_OV       13
`define STAT_SUPPLY_FAIL  14
`define STAT_MAIN_UV      15
// Fault strobe length in oscillator cycles
`define FAULT_PULSE_CYC   1
`define SYNC_STAGES       2

`endif

// >>> rtl/fault_protection_manager_pkg.sv
// Types shared by the fault protection manager and its helpers.
// Assumes the defines header is on the include path.
`include "fault_protection_manager_defines.svh"
package fault_protection_manager_pkg;

    // Raw fault detector levels from the analog front end
    typedef struct packed {
        logic wdog_fail;
        logic reg_overtemp;
        logic reg_below_reset;
        logic reg_prewarn;
        logic reg_overcurrent;
        logic lsw_fault;
        logic lamp_fault;
        logic supply_fault;
        logic bat_uv;
        logic bat_ov;
        logic main_uv;
        logic lin_fail;
    } fault_in_t;

    // Control bits written by the host command decoder
    typedef struct packed {
        logic lsw_enable;
        logic lamp_enable;
        logic supply_enable;
        logic bat_lamp_shutdown;
        logic wdog_stop_enable;
    } ctrl_t;

    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_ACTIVE,
        MODE_STOP,
        MODE_SLEEP
    } op_mode_t;

endpackage

// >>> rtl/sync_bit.sv
// Two-stage level synchroniser into a destination clock.
// Assumes the input is a quasi-static level from another domain.
`timescale 1ns/1ps
module sync_bit
    import fault_protection_manager_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// >>> rtl/latch_flag.sv
// Sticky status flag: set by an event, cleared by a status read.
// Assumes set and clear are single-domain, same-cycle signals.
`timescale 1ns/1ps
module latch_flag
    import fault_protection_manager_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      flag_reg
);

    // Set wins over clear so a coincident event is never lost
    always_ff @(posedge clk) begin
        if (rst)
            flag_reg <= 1'b0;
        else if (set_in)
            flag_reg <= 1'b1;   // R16
        else if (clr_in)
            flag_reg <= 1'b0;
    end

endmodule

// >>> tb/host_model.sv
// Host side of the serial link: select, data line and read strobe.
// Assumes a free-running link_clk; the bench calls its tasks.
`timescale 1ns/1ps
module host_model (
    // Serial link
    input  wire logic link_clk,
    output logic      chip_select_n,
    output logic      serial_in_line,
    output logic      status_read
);
    // Idle: deselected, no read pending
    initial begin
        chip_select_n  = 1'b1;
        serial_in_line = 1'b0;
        status_read    = 1'b0;
    end
    // Select the device and hold the data bit while selected
    task automatic sel(input logic din);
        @(negedge link_clk);
        chip_select_n  = 1'b0;
        serial_in_line = din;
        repeat (3) @(negedge link_clk);
    endtask
    // Finish the access; released line flips so it never looks held
    task automatic desel;
        status_read    = 1'b1;
        @(negedge link_clk);
        status_read    = 1'b0;
        chip_select_n  = 1'b1;
        serial_in_line = ~serial_in_line;
    endtask
endmodule

// >>> tb/fault_protection_manager_tb.sv
// Bench of the fault protection manager: fault, wake and link tests.
// Assumes the package, header and host_model are compiled first.
`timescale 1ns/1ps
`include "fault_protection_manager_defines.svh"
module fault_protection_manager_tb;
    import fault_protection_manager_pkg::*;
    // ****************************************************
    // Stimulus and observed signals
    // ****************************************************
    logic core_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, link_rst = 1'b1;
    logic cs_n, sin, srd, lin_wake, cur_hi, ctrl_write, rst_n, flt_n;
    logic rx_n, sout, lsw_en, lamp_en, sup_en, reg_en, wd_en;
    logic [`SENSE_N-1:0] sense;
    logic [`STAT_W-1:0]  status;
    fault_in_t fault_in;
    ctrl_t     ctrl_in;
    op_mode_t  mode_in;
    int n_fail = 0, cmp_count = 0, lows;
    int bitpos[5] = '{12, 13, 14, 15, 1};
    ctrl_t all_on = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    // Core and link clocks; their rising edges never coincide
    always #2.5 core_clk = ~core_clk;
    always #6 link_clk = ~link_clk;
    host_model host_u (.link_clk(link_clk), .chip_select_n(cs_n),
        .serial_in_line(sin), .status_read(srd));
    fault_protection_manager dut_u (.core_clk(core_clk), .rst(rst),
        .link_clk(link_clk), .link_rst(link_rst), .chip_select_n(cs_n),
        .serial_in_line(sin), .status_read(srd), .fault_in(fault_in),
        .lin_wake(lin_wake), .sense_wake_input(sense),
        .reg_current_high(cur_hi), .ctrl_in(ctrl_in),
        .ctrl_write(ctrl_write), .mode_in(mode_in),
        .reset_out_n_reg(rst_n), .fault_line_n_reg(flt_n),
        .rx_line_n_reg(rx_n), .serial_out_reg(sout),
        .low_side_switch_en_reg(lsw_en),
        .high_side_lamp_driver_en_reg(lamp_en), .supply_en_reg(sup_en),
        .regulator_output_en_reg(reg_en), .window_watchdog_en_reg(wd_en),
        .status_reg(status));
    // ****************************************************
    // Helpers
    // ****************************************************
    task automatic chk(input string what, input logic seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %b seen %b", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Reads are spaced well beyond the clearing delay of the flags
    task automatic rd;
        host_u.sel(1'b0);
        host_u.desel();
        cyc(10);
    endtask
    task automatic wr(input ctrl_t c);
        ctrl_in = c;
        ctrl_write = 1'b1;
        cyc(1);
        ctrl_write = 1'b0;
        cyc(2);
    endtask
    function automatic fault_in_t one_fault(input int k);
        fault_in_t f;
        f = '0;
        case (k)
            0: f.bat_uv = 1'b1;
            1: f.bat_ov = 1'b1;
            2: f.supply_fault = 1'b1;
            3: f.main_uv = 1'b1;
            default: f.lamp_fault = 1'b1;
        endcase
        return f;
    endfunction
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****************************************************
    // Test sequence
    // ****************************************************
    initial begin
        fault_in = '0; lin_wake = 1'b0; sense = '0; cur_hi = 1'b0;
        ctrl_in = '0; ctrl_write = 1'b0; mode_in = MODE_ACTIVE;
        cyc(3);
        chk("reset_out", rst_n, 1'b0);
        chk("vint_ok", status[`STAT_VINT_OK], 1'b0);
        rst = 1'b0;
        cyc(2);
        link_rst = 1'b0; // Two link edges seen in reset
        cyc(4);
        chk("vint_ok", status[`STAT_VINT_OK], 1'b1);
        wr(all_on);
        // Low-side fault: one-cycle strobe, latched bit, refusal
        fault_in.lsw_fault = 1'b1;
        lows = 0;
        repeat (12) begin
            cyc(1);
            if (flt_n === 1'b0) lows++;
        end
        chk("fault_strobe", lows == `FAULT_PULSE_CYC, 1'b1);
        chk("lsw_en", lsw_en, 1'b0);
        chk("lsw_flag", status[`STAT_LSW_FAIL], 1'b1);
        wr(all_on);
        chk("lsw_refused", lsw_en, 1'b0);
        fault_in = '0;
        rd;
        wr(all_on);
        chk("lsw_back", lsw_en, 1'b1);
        $display("test low_side done");
        // Latched faults and the shutdowns they cause
        for (int k = 0; k < 5; k++) begin
            fault_in = one_fault(k);
            cyc(8);
            fault_in = '0;
            cyc(8);
            chk("latched", status[bitpos[k]], 1'b1);
            chk("lamp_en", lamp_en, !(k < 2 || k == 4));
            chk("sup_en", sup_en, k != 2);
            rd;
            chk("cleared", status[bitpos[k]], 1'b0);
            wr(all_on);
            chk("lamp_back", lamp_en, 1'b1);
        end
        $display("test latched done");
        // LIN failure follows the detector with no latch
        fault_in.lin_fail = 1'b1;
        cyc(8);
        chk("lin_fail", status[`STAT_LIN_INFO], 1'b1);
        host_u.sel(1'b0);
        cyc(2);
        chk("sout_fail", sout, 1'b1);
        host_u.desel();
        fault_in = '0;
        cyc(10);
        chk("lin_gone", status[`STAT_LIN_INFO], 1'b0);
        host_u.sel(1'b1);
        cyc(2);
        chk("sout_or", sout, 1'b1);
        host_u.desel();
        host_u.sel(1'b0);
        cyc(2);
        chk("sout_clean", sout, 1'b0);
        host_u.desel();
        cyc(10);
        $display("test link done");
        // Watchdog failure and regulator overtemperature
        fault_in.wdog_fail = 1'b1;
        cyc(8);
        chk("wd_reset", rst_n, 1'b0);
        fault_in = '0;
        cyc(8);
        chk("wd_flag", status[`STAT_WDOG_RESET], 1'b1);
        rd;
        chk("wd_clear", status[`STAT_WDOG_RESET], 1'b0);
        fault_in.reg_overtemp = 1'b1;
        cyc(8);
        chk("reg_off", reg_en, 1'b0);
        fault_in.reg_below_reset = 1'b1;
        cyc(8);
        chk("reg_reset", rst_n, 1'b0);
        fault_in = '0;
        cyc(8);
        chk("reg_auto", reg_en, 1'b1);
        $display("test reset done");
        // Stop mode watchdog and wake signalling
        mode_in = MODE_STOP;
        cyc(8);
        chk("wd_off", wd_en, 1'b0);
        ctrl_in.wdog_stop_enable = 1'b1;
        cyc(4);
        chk("wd_cmd", wd_en, 1'b1);
        ctrl_in.wdog_stop_enable = 1'b0;
        cur_hi = 1'b1;
        cyc(8);
        chk("wd_on", wd_en, 1'b1);
        lin_wake = 1'b1;
        cyc(8);
        lin_wake = 1'b0;
        cyc(4);
        chk("rx_wake", rx_n, 1'b0);
        chk("sout_wake", sout, 1'b0);
        chk("lin_src", status[`STAT_LIN_INFO], 1'b1);
        rd;
        mode_in = MODE_SLEEP;
        cyc(4);
        sense[0] = 1'b1;
        cyc(12);
        chk("sout_sense", sout, 1'b0);
        chk("sense_src", status[`STAT_SENSE_LO], 1'b1);
        $display("test wake done");
        // Mid-run reset clears configuration set just before it
        wr(all_on);
        chk("cfg_set", lsw_en & lamp_en, 1'b1);
        rst = 1'b1;
        cyc(3);
        chk("reset_mid", rst_n, 1'b0);
        rst = 1'b0;
        cyc(6);
        chk("cfg_clear", lsw_en | lamp_en, 1'b0);
        $display("test rerun done");
        end_sim;
    end
endmodule
